// [rtl/hpb_bridge.sv]
`timescale 1ns/1ns
// Behaviour
// - Latency bound on later data phases when its bit and delayed transactions are set.
// - Deferred mode hard-failure reply asserts snoop defer strobe only when enabled.
// - Synchronous mode hard-failure reply asserts snoop defer strobe only when enabled.
// - Host lock is carried to PCI only when host-lock forwarding is set.
// - PCI lock is carried to the host only when PCI-lock forwarding is set.
// - Shutdown becomes I/O write to port 92 if enabled, else special cycle.
// - Defer-retry on outbound full, or on both queues full when criterion set.
// - Synchronous mode stalls in snoop phase; deferred mode defers and replies later.
// - Reissue retried command up to the limit, then abort and end host cycle.
// - Escalated master abort sets status 14 and 13 and drives system error.
// - Unescalated master abort replies normal or hard failure per reply-select bit.
// - Enabled data parity error sets local bit, status 15, system error.
// - Enabled address parity error sets local bit, status 15, system error.
// - Target abort replies normal; if escalated sets status 14, 12 and system error.
// - Enabled single-bit ECC error sets status 14, local bit, system error.
// - Enabled multi-bit ECC error sets status 14, local bit, system error.
// - Error status is write-one-to-clear; zero writes leave bits alone.
module hpb_bridge
    import hpb_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic HOST_REQ,
    input wire logic HOST_LOCK,
    input wire logic HOST_SHUTDOWN,
    input wire logic OBQ_FULL,
    input wire logic IBQ_FULL,
    input wire logic PCI_DONE,
    input wire logic PCI_RETRY,
    input wire logic PCI_MASTER_ABORT,
    input wire logic PCI_TARGET_ABORT,
    input wire logic PCI_LOCK_IN,
    input wire logic DT_ENABLE,
    input wire logic SERR_ENABLE,
    input wire logic DATA_PAR_ERR,
    input wire logic ADDR_PAR_ERR,
    input wire logic ECC_SINGLE_ERR,
    input wire logic ECC_MULTI_ERR,
    output logic SNOOP_STALL,
    output logic HOST_DEFERRED,
    output logic HOST_DEFER_RETRY,
    output logic SNOOP_DEFER_STROBE,
    output logic REPLY_VALID,
    output logic HOST_REPLY_HARD,
    output logic DEFER_REPLY,
    output logic PCI_ISSUE,
    output hpb_pcmd_t PCI_CMD_KIND,
    output logic [15:0] PCI_IO_ADDR,
    output logic PCI_LOCK_OUT,
    output logic HOST_LOCK_OUT,
    output logic LATENCY_BOUND,
    output logic [3:0] STD_STATUS_SET,
    output logic SYSTEM_ERROR_LINE_N
);

    hpb_state_t r_reg;
    hpb_state_t r_next;
    logic crit;
    logic accept;
    logic wait_st;

    // A full outbound queue would deadlock the host, so the head is pushed back.
    assign crit = r_reg.cmd[HPB_CMD_RCRIT] ? (OBQ_FULL && IBQ_FULL) : OBQ_FULL;
    assign accept = (r_reg.state == HPB_IDLE) && HOST_REQ && !crit;
    assign wait_st = (r_reg.state == HPB_WAIT);

    always_comb begin
        logic [3:0] std_set;
        logic [7:0] stat_set;
        logic serr_req;
        logic reply;
        logic hard;
        std_set = 4'h0;
        stat_set = 8'h00;
        serr_req = 1'b0;
        reply = 1'b0;
        hard = 1'b0;
        r_next = r_reg;
        r_next.o.deferred = 1'b0;
        r_next.o.defer_retry = 1'b0;
        r_next.o.snoop_defer = 1'b0;
        r_next.o.reply_valid = 1'b0;
        r_next.o.reply_hard = 1'b0;
        r_next.o.defer_reply = 1'b0;
        r_next.o.pci_issue = 1'b0;
        r_next.o.rdata = 8'h00;

        if (REG_WR) begin
            case (REG_ADDR)
                HPB_OFS_CMD: r_next.cmd = REG_WDATA;
                HPB_OFS_RETRY: r_next.retry_lim = REG_WDATA;
                HPB_OFS_ECTL_LO: r_next.ectl[7:0] = REG_WDATA & HPB_ECTL_MASK[7:0];
                HPB_OFS_ECTL_HI: r_next.ectl[15:8] = REG_WDATA & HPB_ECTL_MASK[15:8];
                HPB_OFS_ESTAT: r_next.estat = r_reg.estat & ~REG_WDATA;
                default: r_next.cmd = r_reg.cmd;
            endcase
        end
        if (REG_RD) begin
            case (REG_ADDR)
                HPB_OFS_CMD: r_next.o.rdata = r_reg.cmd;
                HPB_OFS_RETRY: r_next.o.rdata = r_reg.retry_lim;
                HPB_OFS_ECTL_LO: r_next.o.rdata = r_reg.ectl[7:0];
                HPB_OFS_ECTL_HI: r_next.o.rdata = r_reg.ectl[15:8];
                HPB_OFS_ESTAT: r_next.o.rdata = r_reg.estat;
                default: r_next.o.rdata = 8'h00;
            endcase
        end

        if (DATA_PAR_ERR && r_reg.ectl[HPB_ECTL_DPAR]) begin
            stat_set[HPB_ESTAT_DPAR] = 1'b1;
            std_set[HPB_STD_DPE] = 1'b1;
            serr_req = 1'b1;
        end
        if (ADDR_PAR_ERR && r_reg.ectl[HPB_ECTL_APAR]) begin
            stat_set[HPB_ESTAT_APAR] = 1'b1;
            std_set[HPB_STD_DPE] = 1'b1;
            serr_req = 1'b1;
        end
        if (ECC_SINGLE_ERR && r_reg.ectl[HPB_ECTL_ECC1]) begin
            stat_set[HPB_ESTAT_ECC1] = 1'b1;
            std_set[HPB_STD_SSE] = 1'b1;
            serr_req = 1'b1;
        end
        if (ECC_MULTI_ERR && r_reg.ectl[HPB_ECTL_ECC2]) begin
            stat_set[HPB_ESTAT_ECC2] = 1'b1;
            std_set[HPB_STD_SSE] = 1'b1;
            serr_req = 1'b1;
        end

        case (r_reg.state)
            HPB_IDLE: begin
                if (HOST_REQ && crit) begin
                    r_next.o.defer_retry = 1'b1;
                end else if (accept) begin
                    r_next.retry_cnt = 8'h00;
                    // Synchronous mode holds the snoop phase; deferred mode lets it go.
                    r_next.o.stall = !r_reg.cmd[HPB_CMD_DEFMODE];
                    r_next.o.deferred = r_reg.cmd[HPB_CMD_DEFMODE];
                    r_next.o.pci_lock = HOST_LOCK && r_reg.cmd[HPB_CMD_HLOCK];
                    if (!HOST_SHUTDOWN) begin
                        r_next.kind = HPB_PC_FWD;
                    end else if (r_reg.cmd[HPB_CMD_SHUT]) begin
                        r_next.kind = HPB_PC_IOWR;
                    end else begin
                        r_next.kind = HPB_PC_SPECIAL;
                    end
                    r_next.state = HPB_ISSUE;
                end
            end
            HPB_ISSUE: begin
                r_next.o.pci_issue = 1'b1;
                r_next.o.pci_kind = r_reg.kind;
                r_next.o.pci_io_addr = (r_reg.kind == HPB_PC_IOWR) ? HPB_SHUTDOWN_PORT : 16'h0000;
                r_next.state = HPB_WAIT;
            end
            HPB_WAIT: begin
                if (PCI_DONE) begin
                    reply = 1'b1;
                end else if (PCI_RETRY) begin
                    if (r_reg.retry_cnt < r_reg.retry_lim) begin
                        r_next.retry_cnt = r_reg.retry_cnt + 8'h01;
                        r_next.state = HPB_ISSUE;
                    end else begin
                        reply = 1'b1;
                        hard = 1'b1;
                    end
                end else if (PCI_MASTER_ABORT) begin
                    reply = 1'b1;
                    if (r_reg.ectl[HPB_ECTL_MA_SERR]) begin
                        std_set[HPB_STD_SSE] = 1'b1;
                        std_set[HPB_STD_RMA] = 1'b1;
                        serr_req = 1'b1;
                    end else begin
                        hard = r_reg.ectl[HPB_ECTL_MA_HARD];
                    end
                end else if (PCI_TARGET_ABORT) begin
                    reply = 1'b1;
                    if (r_reg.ectl[HPB_ECTL_TA]) begin
                        std_set[HPB_STD_SSE] = 1'b1;
                        std_set[HPB_STD_RTA] = 1'b1;
                        serr_req = 1'b1;
                    end
                end
            end
            default: r_next.state = HPB_IDLE;
        endcase

        if (reply) begin
            r_next.state = HPB_IDLE;
            r_next.o.stall = 1'b0;
            r_next.o.pci_lock = 1'b0;
            r_next.o.reply_valid = 1'b1;
            r_next.o.reply_hard = hard;
            r_next.o.defer_reply = r_reg.cmd[HPB_CMD_DEFMODE];
            if (r_reg.cmd[HPB_CMD_DEFMODE]) begin
                r_next.o.snoop_defer = hard && r_reg.cmd[HPB_CMD_DEFHF];
            end else begin
                r_next.o.snoop_defer = hard && r_reg.cmd[HPB_CMD_SYNHF];
            end
        end

        // New events are merged after the clear so that a set wins.
        r_next.estat = r_next.estat | stat_set;
        r_next.o.std_set = std_set;
        r_next.o.sys_err_n = !(serr_req && SERR_ENABLE);
        r_next.o.host_lock = PCI_LOCK_IN && r_reg.cmd[HPB_CMD_PLOCK];
        // Only meaningful with delayed transactions on; a misset bit alone is ignored.
        r_next.o.lat_bound = r_reg.cmd[HPB_CMD_LAT] && DT_ENABLE;
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            r_reg <= '0;
            r_reg.state <= HPB_IDLE;
            r_reg.cmd <= HPB_RST_CMD;
            r_reg.retry_lim <= HPB_RST_RETRY;
            r_reg.ectl <= HPB_RST_ECTL;
            r_reg.estat <= HPB_RST_ESTAT;
            r_reg.o.sys_err_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign REG_RDATA = r_reg.o.rdata;
    assign SNOOP_STALL = r_reg.o.stall;
    assign HOST_DEFERRED = r_reg.o.deferred;
    assign HOST_DEFER_RETRY = r_reg.o.defer_retry;
    assign SNOOP_DEFER_STROBE = r_reg.o.snoop_defer;
    assign REPLY_VALID = r_reg.o.reply_valid;
    assign HOST_REPLY_HARD = r_reg.o.reply_hard;
    assign DEFER_REPLY = r_reg.o.defer_reply;
    assign PCI_ISSUE = r_reg.o.pci_issue;
    assign PCI_CMD_KIND = r_reg.o.pci_kind;
    assign PCI_IO_ADDR = r_reg.o.pci_io_addr;
    assign PCI_LOCK_OUT = r_reg.o.pci_lock;
    assign HOST_LOCK_OUT = r_reg.o.host_lock;
    assign LATENCY_BOUND = r_reg.o.lat_bound;
    assign STD_STATUS_SET = r_reg.o.std_set;
    assign SYSTEM_ERROR_LINE_N = r_reg.o.sys_err_n;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SRST);

    lat_bound_a: assert property (
        LATENCY_BOUND == $past(r_reg.cmd[HPB_CMD_LAT] && DT_ENABLE))
        else $error("Latency bound does not follow its enables.");
    defer_hf_a: assert property (
        (REPLY_VALID && HOST_REPLY_HARD && DEFER_REPLY)
        |-> SNOOP_DEFER_STROBE == $past(r_reg.cmd[HPB_CMD_DEFHF]))
        else $error("Deferred-mode snoop defer does not match its enable.");
    sync_hf_a: assert property (
        (REPLY_VALID && HOST_REPLY_HARD && !DEFER_REPLY)
        |-> SNOOP_DEFER_STROBE == $past(r_reg.cmd[HPB_CMD_SYNHF]))
        else $error("Synchronous-mode snoop defer does not match its enable.");
    host_lock_a: assert property (
        accept |=> PCI_LOCK_OUT == $past(HOST_LOCK && r_reg.cmd[HPB_CMD_HLOCK]))
        else $error("Host lock forwarding wrong.");
    pci_lock_a: assert property (
        HOST_LOCK_OUT == $past(PCI_LOCK_IN && r_reg.cmd[HPB_CMD_PLOCK]))
        else $error("PCI lock forwarding wrong.");
    shutdown_xlat_a: assert property (
        (accept && HOST_SHUTDOWN) |-> ##2 PCI_ISSUE
        && PCI_CMD_KIND == ($past(r_reg.cmd[HPB_CMD_SHUT], 2) ? HPB_PC_IOWR : HPB_PC_SPECIAL))
        else $error("Shutdown cycle translated wrongly.");
    retry_crit_a: assert property (
        (r_reg.state == HPB_IDLE && HOST_REQ && crit) |=> HOST_DEFER_RETRY && !PCI_ISSUE)
        else $error("Queue-full head not defer-retried.");
    mode_sel_a: assert property (
        accept |=> (SNOOP_STALL == !$past(r_reg.cmd[HPB_CMD_DEFMODE])
        && HOST_DEFERRED == $past(r_reg.cmd[HPB_CMD_DEFMODE]))
        ##1 PCI_ISSUE)
        else $error("Stall or defer not chosen by mode.");
    retry_limit_a: assert property (
        (wait_st && !PCI_DONE && PCI_RETRY && r_reg.retry_cnt >= r_reg.retry_lim)
        |=> REPLY_VALID && HOST_REPLY_HARD && !PCI_ISSUE)
        else $error("Retry limit did not abort the command.");
    ma_serr_a: assert property (
        (wait_st && !PCI_DONE && !PCI_RETRY && PCI_MASTER_ABORT && r_reg.ectl[HPB_ECTL_MA_SERR])
        |=> STD_STATUS_SET[HPB_STD_SSE] && STD_STATUS_SET[HPB_STD_RMA]
        && SYSTEM_ERROR_LINE_N == !$past(SERR_ENABLE))
        else $error("Escalated master abort not reported.");
    ma_reply_a: assert property (
        (wait_st && !PCI_DONE && !PCI_RETRY && PCI_MASTER_ABORT && !r_reg.ectl[HPB_ECTL_MA_SERR])
        |=> REPLY_VALID && HOST_REPLY_HARD == $past(r_reg.ectl[HPB_ECTL_MA_HARD]))
        else $error("Master abort reply type wrong.");
    dpar_a: assert property (
        (DATA_PAR_ERR && r_reg.ectl[HPB_ECTL_DPAR])
        |=> r_reg.estat[HPB_ESTAT_DPAR] && STD_STATUS_SET[HPB_STD_DPE])
        else $error("Data parity error not recorded.");
    apar_a: assert property (
        (ADDR_PAR_ERR && r_reg.ectl[HPB_ECTL_APAR] && SERR_ENABLE)
        |=> r_reg.estat[HPB_ESTAT_APAR] && !SYSTEM_ERROR_LINE_N)
        else $error("Address parity error not reported.");
    ta_reply_a: assert property (
        (wait_st && !PCI_DONE && !PCI_RETRY && !PCI_MASTER_ABORT && PCI_TARGET_ABORT)
        |=> REPLY_VALID && !HOST_REPLY_HARD
        && STD_STATUS_SET[HPB_STD_RTA] == $past(r_reg.ectl[HPB_ECTL_TA]))
        else $error("Target abort handled wrongly.");
    ecc_single_a: assert property (
        (ECC_SINGLE_ERR && r_reg.ectl[HPB_ECTL_ECC1])
        |=> r_reg.estat[HPB_ESTAT_ECC1] && STD_STATUS_SET[HPB_STD_SSE])
        else $error("Single-bit ECC error not recorded.");
    ecc_multi_a: assert property (
        (ECC_MULTI_ERR && r_reg.ectl[HPB_ECTL_ECC2])
        |=> r_reg.estat[HPB_ESTAT_ECC2] && STD_STATUS_SET[HPB_STD_SSE])
        else $error("Multi-bit ECC error not recorded.");
    stat_w1c_a: assert property (
        (REG_WR && REG_ADDR == HPB_OFS_ESTAT && !DATA_PAR_ERR && !ADDR_PAR_ERR
        && !ECC_SINGLE_ERR && !ECC_MULTI_ERR)
        |=> r_reg.estat == ($past(r_reg.estat) & ~$past(REG_WDATA)))
        else $error("Error status write-one-to-clear wrong.");

    // These guard paths that the register tests seldom reach.
    defer_strobe_hard_a: assert property (
        SNOOP_DEFER_STROBE |-> REPLY_VALID && HOST_REPLY_HARD)
        else $error("Snoop defer strobe without a hard-failure reply.");

    stall_release_a: assert property (
        REPLY_VALID |-> !SNOOP_STALL && !PCI_LOCK_OUT)
        else $error("Stall or lock still held at the reply.");

    // A stale port address would slip past the kind check alone.
    shutdown_port_a: assert property (
        (accept && HOST_SHUTDOWN && r_reg.cmd[HPB_CMD_SHUT])
        |-> ##2 PCI_IO_ADDR == HPB_SHUTDOWN_PORT)
        else $error("Shutdown write not aimed at its port.");

    forward_kind_a: assert property (
        (accept && !HOST_SHUTDOWN)
        |-> ##2 PCI_CMD_KIND == HPB_PC_FWD && PCI_IO_ADDR == 16'h0000)
        else $error("Plain host cycle not forwarded as is.");

    retry_reissue_a: assert property (
        (wait_st && !PCI_DONE && PCI_RETRY && r_reg.retry_cnt < r_reg.retry_lim)
        |=> !REPLY_VALID ##1 PCI_ISSUE)
        else $error("Retried command not reissued.");

    queue_accept_a: assert property (
        (r_reg.state == HPB_IDLE && HOST_REQ && !crit)
        |=> !HOST_DEFER_RETRY && (SNOOP_STALL || HOST_DEFERRED))
        else $error("Request refused although the queues have room.");

    // A masked system error must stay quiet whatever the error enables say.
    serr_gate_a: assert property (
        !SERR_ENABLE |=> SYSTEM_ERROR_LINE_N)
        else $error("System error driven while disabled.");

    dpar_serr_a: assert property (
        (DATA_PAR_ERR && r_reg.ectl[HPB_ECTL_DPAR] && SERR_ENABLE)
        |=> !SYSTEM_ERROR_LINE_N)
        else $error("Data parity error did not drive system error.");

    ecc_serr_a: assert property (
        (ECC_SINGLE_ERR && r_reg.ectl[HPB_ECTL_ECC1] && SERR_ENABLE)
        |=> !SYSTEM_ERROR_LINE_N)
        else $error("Single-bit ECC error did not drive system error.");

    stat_set_only_a: assert property (
        !(DATA_PAR_ERR || ADDR_PAR_ERR || ECC_SINGLE_ERR || ECC_MULTI_ERR)
        |=> (r_reg.estat & ~$past(r_reg.estat)) == 8'h00)
        else $error("Error status bit set without an event.");

endmodule

// [rtl/hpb_pkg.sv]
package hpb_pkg;

    // Register byte offsets on the plain register port.
    localparam logic [7:0] HPB_OFS_CMD = 8'h62;
    localparam logic [7:0] HPB_OFS_RETRY = 8'h63;
    localparam logic [7:0] HPB_OFS_ECTL_LO = 8'h64;
    localparam logic [7:0] HPB_OFS_ECTL_HI = 8'h65;
    localparam logic [7:0] HPB_OFS_ESTAT = 8'h66;

    // Values after reset.
    localparam logic [7:0] HPB_RST_CMD = 8'h00;
    localparam logic [7:0] HPB_RST_RETRY = 8'h02;
    localparam logic [15:0] HPB_RST_ECTL = 16'h0000;
    localparam logic [7:0] HPB_RST_ESTAT = 8'h00;

    // Implemented bits; reserved bits read as zero.
    localparam logic [15:0] HPB_ECTL_MASK = 16'h01B7;

    // Bridge command fields.
    localparam int HPB_CMD_LAT = 7;
    localparam int HPB_CMD_DEFHF = 6;
    localparam int HPB_CMD_SYNHF = 5;
    localparam int HPB_CMD_HLOCK = 4;
    localparam int HPB_CMD_PLOCK = 3;
    localparam int HPB_CMD_SHUT = 2;
    localparam int HPB_CMD_RCRIT = 1;
    localparam int HPB_CMD_DEFMODE = 0;

    // Error control fields.
    localparam int HPB_ECTL_MA_SERR = 8;
    localparam int HPB_ECTL_MA_HARD = 7;
    localparam int HPB_ECTL_DPAR = 5;
    localparam int HPB_ECTL_APAR = 4;
    localparam int HPB_ECTL_TA = 2;
    localparam int HPB_ECTL_ECC1 = 1;
    localparam int HPB_ECTL_ECC2 = 0;

    // Error status fields.
    localparam int HPB_ESTAT_DPAR = 5;
    localparam int HPB_ESTAT_APAR = 4;
    localparam int HPB_ESTAT_ECC1 = 1;
    localparam int HPB_ESTAT_ECC2 = 0;

    // Standard status set pulses: index 3..0 stand for bits 15..12.
    localparam int HPB_STD_DPE = 3;
    localparam int HPB_STD_SSE = 2;
    localparam int HPB_STD_RMA = 1;
    localparam int HPB_STD_RTA = 0;

    localparam logic [15:0] HPB_SHUTDOWN_PORT = 16'h0092;

    typedef enum logic [1:0] {
        HPB_PC_FWD = 2'h0,
        HPB_PC_SPECIAL = 2'h1,
        HPB_PC_IOWR = 2'h2
    } hpb_pcmd_t;

    typedef enum logic [2:0] {
        HPB_IDLE = 3'h1,
        HPB_ISSUE = 3'h2,
        HPB_WAIT = 3'h4
    } hpb_fsm_t;

    typedef struct packed {
        logic stall;
        logic deferred;
        logic defer_retry;
        logic snoop_defer;
        logic reply_valid;
        logic reply_hard;
        logic defer_reply;
        logic pci_issue;
        hpb_pcmd_t pci_kind;
        logic [15:0] pci_io_addr;
        logic pci_lock;
        logic host_lock;
        logic lat_bound;
        logic [3:0] std_set;
        logic sys_err_n;
        logic [7:0] rdata;
    } hpb_out_t;

    typedef struct packed {
        hpb_fsm_t state;
        logic [7:0] cmd;
        logic [7:0] retry_lim;
        logic [15:0] ectl;
        logic [7:0] estat;
        logic [7:0] retry_cnt;
        hpb_pcmd_t kind;
        hpb_out_t o;
    } hpb_state_t;

endpackage

// [verif/hpb_pci_agent.sv]
`timescale 1ns/1ns
// Far-side PCI target. Each issued command is answered after DELAY cycles, first with
// RETRY_COUNT retries, then with RESP_KIND (0 done, 1 retry, 2 master abort, 3 target abort).
module hpb_pci_agent
    import hpb_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic NEW_CMD,
    input wire logic PCI_ISSUE,
    input wire logic [1:0] RESP_KIND,
    input wire logic [3:0] RETRY_COUNT,
    input wire logic [3:0] DELAY,
    output logic PCI_DONE,
    output logic PCI_RETRY,
    output logic PCI_MASTER_ABORT,
    output logic PCI_TARGET_ABORT
);
    int tries;
    logic [3:0] code;
    initial begin
        {PCI_TARGET_ABORT, PCI_MASTER_ABORT, PCI_RETRY, PCI_DONE} = 4'h0;
        tries = 0;
        forever begin
            @(posedge CORE_CLK);
            if (SRST || NEW_CMD) begin
                tries = 0;
            end else if (PCI_ISSUE) begin
                repeat (DELAY) @(posedge CORE_CLK);
                // Retries come first so the bridge has to count its reissues.
                code = (tries < RETRY_COUNT) ? 4'h2 : (4'h1 << RESP_KIND);
                tries = tries + 1;
                {PCI_TARGET_ABORT, PCI_MASTER_ABORT, PCI_RETRY, PCI_DONE} <= code;
                @(posedge CORE_CLK);
                {PCI_TARGET_ABORT, PCI_MASTER_ABORT, PCI_RETRY, PCI_DONE} <= 4'h0;
            end
        end
    end
endmodule

// [verif/hpb_bridge_tb_top.sv]
`timescale 1ns/1ns
module hpb_bridge_tb_top import hpb_pkg::*;;
    logic clk, srst, reg_wr, reg_rd, host_req, host_lock, host_shut, obq_full, ibq_full;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic pci_done, pci_retry, pci_ma, pci_ta, pci_lock_in, dt_en, serr_en;
    logic [3:0] err_ev, nr, dly, std_set;
    logic [1:0] rc;
    logic stall, deferred, defer_retry, sdefer, reply_valid, reply_hard, defer_reply;
    logic pci_issue, pci_lock_out, host_lock_out, lat_bound, serr_n;
    hpb_pcmd_t pci_kind;
    logic [15:0] pci_io_addr, res;
    int fail_count, tests_run, cycles;

    hpb_bridge dut (.CORE_CLK(clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .HOST_REQ(host_req),
        .HOST_LOCK(host_lock), .HOST_SHUTDOWN(host_shut), .OBQ_FULL(obq_full),
        .IBQ_FULL(ibq_full), .PCI_DONE(pci_done), .PCI_RETRY(pci_retry),
        .PCI_MASTER_ABORT(pci_ma), .PCI_TARGET_ABORT(pci_ta), .PCI_LOCK_IN(pci_lock_in),
        .DT_ENABLE(dt_en), .SERR_ENABLE(serr_en), .DATA_PAR_ERR(err_ev[3]),
        .ADDR_PAR_ERR(err_ev[2]), .ECC_SINGLE_ERR(err_ev[1]), .ECC_MULTI_ERR(err_ev[0]),
        .SNOOP_STALL(stall), .HOST_DEFERRED(deferred), .HOST_DEFER_RETRY(defer_retry),
        .SNOOP_DEFER_STROBE(sdefer), .REPLY_VALID(reply_valid), .HOST_REPLY_HARD(reply_hard),
        .DEFER_REPLY(defer_reply), .PCI_ISSUE(pci_issue), .PCI_CMD_KIND(pci_kind),
        .PCI_IO_ADDR(pci_io_addr), .PCI_LOCK_OUT(pci_lock_out),
        .HOST_LOCK_OUT(host_lock_out), .LATENCY_BOUND(lat_bound),
        .STD_STATUS_SET(std_set), .SYSTEM_ERROR_LINE_N(serr_n));

    hpb_pci_agent u_agent (.CORE_CLK(clk), .SRST(srst), .NEW_CMD(host_req),
        .PCI_ISSUE(pci_issue), .RESP_KIND(rc), .RETRY_COUNT(nr), .DELAY(dly),
        .PCI_DONE(pci_done), .PCI_RETRY(pci_retry), .PCI_MASTER_ABORT(pci_ma),
        .PCI_TARGET_ABORT(pci_ta));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task end_sim;
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    task setc(input logic [7:0] c, input logic [15:0] e);
        wr(8'h62, c);
        wr(8'h64, e[7:0]);
        wr(8'h65, e[15:8]);
    endtask

    // Result: issues[15:14] kind[13:12] stall defer retry hard strobe dreply lock serr std[3:0].
    task hc(input logic lk, input logic sh, input logic [1:0] q, input logic [1:0] k,
            input logic [3:0] n, input logic [15:0] exp);
        int i;
        int ni;
        res = 16'h0000;
        ni = 0;
        @(posedge clk);
        rc <= k;
        nr <= n;
        host_req <= 1'b1;
        host_lock <= lk;
        host_shut <= sh;
        {obq_full, ibq_full} <= q;
        @(posedge clk);
        host_req <= 1'b0;
        for (i = 0; i < 200; i++) begin
            #1;
            res[11] |= stall;
            res[10] |= deferred;
            res[9] |= defer_retry;
            if (pci_issue === 1'b1) begin
                ni++;
                res[13:12] = pci_kind;
                res[5] = pci_lock_out;
            end
            if (reply_valid === 1'b1) begin
                res[8:6] = {reply_hard, sdefer, defer_reply};
                res[4:0] = {~serr_n, std_set};
                break;
            end
            if (defer_retry !== 1'b0) break;
            @(posedge clk);
        end
        res[15:14] = ni[1:0];
        chk(res, exp);
        @(posedge clk) {obq_full, ibq_full} <= 2'b00;
    endtask

    // Error event b: 0 multi-bit, 1 single-bit, 2 address parity, 3 data parity.
    task ev(input int b, input logic [3:0] sexp, input logic se);
        @(posedge clk);
        err_ev[b] <= 1'b1;
        @(posedge clk);
        err_ev[b] <= 1'b0;
        #1;
        chk({11'h000, ~serr_n, std_set}, {11'h000, se, sexp});
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        {srst, reg_wr, reg_rd, host_req, host_lock, host_shut, obq_full, ibq_full} = 8'hFF;
        {reg_wr, reg_rd, host_req, host_lock, host_shut, obq_full, ibq_full} = 7'h00;
        {reg_addr, reg_wdata, err_ev, rc, nr} = 26'h0;
        {pci_lock_in, dt_en, serr_en} = 3'b000;
        dly = 4'h3;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd(8'h62, 8'h00);
        rd(8'h63, 8'h02);
        rd(8'h64, 8'h00);
        rd(8'h65, 8'h00);
        rd(8'h66, 8'h00);
        wr(8'h70, 8'hFF);
        rd(8'h70, 8'h00);
        wr(8'h64, 8'hFF);
        rd(8'h64, 8'hB7);
        wr(8'h65, 8'hFF);
        rd(8'h65, 8'h01);
        @(posedge clk) pci_lock_in <= 1'b1;
        setc(8'h80, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        chk({14'h0, lat_bound, host_lock_out}, 16'h0000);
        @(posedge clk) dt_en <= 1'b1;
        wr(8'h62, 8'h88);
        repeat (2) @(posedge clk);
        #1;
        chk({14'h0, lat_bound, host_lock_out}, 16'h0003);
        @(posedge clk) serr_en <= 1'b1;
        wr(8'h62, 8'h00);
        for (int b = 0; b < 4; b++) ev(b, 4'h0, 1'b0);
        wr(8'h64, 8'h33);
        for (int b = 0; b < 4; b++) ev(b, (b > 1) ? 4'h8 : 4'h4, 1'b1);
        rd(8'h66, 8'h33);
        wr(8'h66, 8'h11);
        rd(8'h66, 8'h22);
        wr(8'h66, 8'h00);
        rd(8'h66, 8'h22);
        @(posedge clk) serr_en <= 1'b0;
        ev(0, 4'h4, 1'b0);
        @(posedge clk) serr_en <= 1'b1;
        wr(8'h66, 8'hFF);
        rd(8'h66, 8'h00);
        setc(8'h00, 16'h0000);
        hc(0, 0, 2'b00, 0, 0, 16'h4800);
        @(posedge clk) dly <= 4'h0;
        hc(1, 0, 2'b00, 0, 0, 16'h4800);
        wr(8'h62, 8'h10);
        hc(1, 0, 2'b00, 0, 0, 16'h4820);
        wr(8'h62, 8'h00);
        hc(0, 1, 2'b00, 0, 0, 16'h5800);
        chk(pci_io_addr, 16'h0000);
        wr(8'h62, 8'h04);
        hc(0, 1, 2'b00, 0, 0, 16'h6800);
        chk(pci_io_addr, 16'h0092);
        wr(8'h62, 8'h01);
        hc(0, 0, 2'b00, 0, 0, 16'h4440);
        wr(8'h62, 8'h00);
        hc(0, 0, 2'b10, 0, 0, 16'h0200);
        wr(8'h62, 8'h02);
        hc(0, 0, 2'b10, 0, 0, 16'h4800);
        hc(0, 0, 2'b11, 0, 0, 16'h0200);
        wr(8'h62, 8'h00);
        hc(0, 0, 2'b00, 0, 5, 16'hC900);
        wr(8'h63, 8'h01);
        hc(0, 0, 2'b00, 0, 1, 16'h8800);
        hc(0, 0, 2'b00, 0, 5, 16'h8900);
        wr(8'h62, 8'h20);
        hc(0, 0, 2'b00, 0, 5, 16'h8980);
        wr(8'h62, 8'h40);
        hc(0, 0, 2'b00, 0, 5, 16'h8900);
        wr(8'h62, 8'h01);
        hc(0, 0, 2'b00, 0, 5, 16'h8540);
        wr(8'h62, 8'h41);
        hc(0, 0, 2'b00, 0, 5, 16'h85C0);
        setc(8'h00, 16'h0000);
        hc(0, 0, 2'b00, 2, 0, 16'h4800);
        setc(8'h00, 16'h0080);
        hc(0, 0, 2'b00, 2, 0, 16'h4900);
        setc(8'h20, 16'h0080);
        hc(0, 0, 2'b00, 2, 0, 16'h4980);
        setc(8'h00, 16'h0100);
        hc(0, 0, 2'b00, 2, 0, 16'h4816);
        setc(8'h00, 16'h0000);
        hc(0, 0, 2'b00, 3, 0, 16'h4800);
        setc(8'h00, 16'h0004);
        hc(0, 0, 2'b00, 3, 0, 16'h4815);
        end_sim();
    end
endmodule
